/* logic/adctw_cfg.svh */
`ifndef ADCTW_CFG_SVH
`define ADCTW_CFG_SVH
`define ADCTW_AW 6
`define ADCTW_DW 32
`define ADCTW_RW 12
`define ADCTW_NTRIG 16
`define ADCTW_OFS_CR0 6'h00
`define ADCTW_OFS_CR1 6'h04
`define ADCTW_OFS_START 6'h08
`define ADCTW_OFS_VTH 6'h14
`define ADCTW_OFS_VTL 6'h18
`define ADCTW_OFS_TRIG 6'h1C
`define ADCTW_OFS_RES0 6'h20
`define ADCTW_OFS_IER 6'h34
`define ADCTW_OFS_ICR 6'h38
`define ADCTW_OFS_ISR 6'h3C
`define ADCTW_CR0_MODE_HI 4
`define ADCTW_CR0_MODE_LO 2
`define ADCTW_CR0_TEMP_SENSOR_ENABLE 5
`define ADCTW_CR0_BUF 13
`define ADCTW_CR1_CHANNEL_SELECT_HI 3
`define ADCTW_CR1_CHANNEL_SELECT_LO 0
`define ADCTW_CR1_WDCH_HI 7
`define ADCTW_CR1_WDCH_LO 4
`define ADCTW_CR1_WDALL 8
`define ADCTW_START_BIT 0
`define ADCTW_CH_TEMP 4'hE
`define ADCTW_MODE_SINGLE 3'h0
`define ADCTW_NFLAG 7
`define ADCTW_F_EOC 0
`define ADCTW_F_EOS 1
`define ADCTW_F_EOA 2
`define ADCTW_F_LOW 3
`define ADCTW_F_HIGH 4
`define ADCTW_F_INR 5
`define ADCTW_F_OVW 6
`define ADCTW_RST_CR0 16'h0000
`define ADCTW_RST_CR1 9'h000
`define ADCTW_RST_TRIG 16'h0000
`define ADCTW_RST_VTH 12'hFFF
`define ADCTW_RST_VTL 12'h000
`define ADCTW_RST_FLAG 7'h00
`define ADCTW_RST_RES 12'h000
`define ADCTW_RST_CHAN 4'h0
`endif

/* logic/adctw_cmp_if.sv */
`timescale 1ns/10ps
interface adctw_cmp_if;
  logic valid;
  adctw_pkg::adctw_sample_type result;
  adctw_pkg::adctw_sample_type vth;
  adctw_pkg::adctw_sample_type vtl;
  logic armed;
  logic hit_high;
  logic hit_low;
  logic hit_inr;
  modport ctrl (output valid, result, vth, vtl, armed, input hit_high, hit_low, hit_inr);
  modport cmp (input valid, result, vth, vtl, armed, output hit_high, hit_low, hit_inr);
endinterface : adctw_cmp_if

/* logic/adctw_pkg.sv */
package adctw_pkg;
  typedef enum logic [0:0] {
    st_idle = 1'b0,
    st_busy = 1'b1
  } adctw_state_type;
  typedef logic [11:0] adctw_sample_type;
endpackage : adctw_pkg

/* logic/adctw_top.sv */
// Overview of operation
// - Start on software bit or enabled trigger.
// - Sixteen independent trigger enable bits.
// - Bits 15,14,12: port B pin groups.
// - Bits 10,4,3,2: port A pin groups.
// - Bits 13,11,9,8: I2C, SPI, serial ports.
// - Bits 7,6,5: basic timers three, two, one.
// - Bit 1 general timer, bit 0 advanced.
// - Watchdog needs global enable and channel match.
// - Enabled watchdog flags request interrupt.
// - High flag when result at/above high.
// - Low flag when result below low.
// - In-range flag between low and high.
// - Temperature sensor enable resets off.
// - Channel code 0x0E routes temperature sensor.
// - Mode 0: single conversion into slot zero.
// - Overflow flag and its interrupt.
// - All-conversions-done flag and its interrupt.
// - Sequence-done flag and its interrupt.
// - Conversion-complete flag and its interrupt.
// - Writing 0 clears a flag, 1 keeps.
// - Trigger select register at offset 0x1C.
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/10ps
`include "adctw_cfg.svh"
module adctw_top (
  input wire logic sys_clk_i, // Block clock, 200 MHz.
  input wire logic sys_rst_i, // Asynchronous reset, active high.
  input wire logic [`ADCTW_AW-1:0] reg_addr_i, // Register byte address.
  input wire logic [`ADCTW_DW-1:0] reg_wdata_i, // Write data.
  input wire logic reg_wr_i, // Write strobe.
  input wire logic reg_rd_i, // Read strobe.
  output logic [`ADCTW_DW-1:0] reg_rdata_o, // Read data, cycle after strobe.
  input wire logic portb_hi_group_trig_i, // Port B pins 7..4 interrupt.
  input wire logic portb_mid_group_trig_i, // Port B pins 3..2 interrupt.
  input wire logic portb_lo_group_trig_i, // Port B pins 1..0 interrupt.
  input wire logic porta_top_group_trig_i, // Port A pins 7..6 interrupt.
  input wire logic porta_upper_group_trig_i, // Port A pins 5..4 interrupt.
  input wire logic porta_mid_group_trig_i, // Port A pins 3..2 interrupt.
  input wire logic porta_lo_group_trig_i, // Port A pins 1..0 interrupt.
  input wire logic i2c_irq_i, // I2C interrupt.
  input wire logic spi_irq_i, // SPI interrupt.
  input wire logic serial_port_two_irq_i, // Second serial port interrupt.
  input wire logic serial_port_one_irq_i, // First serial port interrupt.
  input wire logic basic_timer_three_irq_i, // Basic timer three interrupt.
  input wire logic basic_timer_two_irq_i, // Basic timer two interrupt.
  input wire logic basic_timer_one_irq_i, // Basic timer one interrupt.
  input wire logic general_timer_irq_i, // General timer interrupt.
  input wire logic advanced_timer_trig_i, // Advanced timer trigger output.
  output logic conv_start_o, // One-cycle start pulse to converter.
  output logic [3:0] conv_channel_o, // Channel for the conversion.
  output logic [2:0] conv_mode_o, // Conversion mode code.
  output logic temp_sensor_enable_o, // Temperature sensor power.
  output logic temp_route_o, // Sensor routed to converter input.
  output logic follower_enable_o, // Built-in input follower on.
  input wire logic conv_done_i, // Converter result valid pulse.
  input wire logic [`ADCTW_RW-1:0] conv_result_i, // Converter result.
  input wire logic sequence_done_i, // Sequence finished pulse.
  input wire logic all_conversions_done_i, // Multiple conversions finished pulse.
  output logic irq_o // Converter interrupt request.
);
  logic [15:0] ctrl0_q;
  logic [8:0] ctrl1_q;
  logic [`ADCTW_NTRIG-1:0] conversion_trigger_select_q;
  adctw_pkg::adctw_sample_type high_threshold_q;
  adctw_pkg::adctw_sample_type low_threshold_q;
  adctw_pkg::adctw_sample_type result_slot_zero_q;
  logic [`ADCTW_NFLAG-1:0] irq_enable_reg_q;
  logic [`ADCTW_NFLAG-1:0] irq_flag_reg_q;
  logic [`ADCTW_NFLAG-1:0] irq_flag_reg_d;
  logic [`ADCTW_NFLAG-1:0] flag_set;
  logic [`ADCTW_NFLAG-1:0] flag_keep;
  logic [3:0] conv_chan_q;
  logic [`ADCTW_DW-1:0] rdata_q;
  logic [`ADCTW_DW-1:0] rdata_d;
  adctw_pkg::adctw_state_type state_q;
  logic [`ADCTW_NTRIG-1:0] trig_src;
  logic trig_hit;
  logic sw_start;
  logic launch;
  logic [3:0] channel_select;
  logic [3:0] watchdog_channel_select;
  logic watchdog_global_enable;
  adctw_cmp_if wd_bus ();

  assign channel_select = ctrl1_q[`ADCTW_CR1_CHANNEL_SELECT_HI:`ADCTW_CR1_CHANNEL_SELECT_LO];
  assign watchdog_channel_select = ctrl1_q[`ADCTW_CR1_WDCH_HI:`ADCTW_CR1_WDCH_LO];
  assign watchdog_global_enable = ctrl1_q[`ADCTW_CR1_WDALL];

  // Trigger vector in the order of the select register bits.
  assign trig_src[15] = portb_hi_group_trig_i;
  assign trig_src[14] = portb_mid_group_trig_i;
  assign trig_src[13] = i2c_irq_i;
  assign trig_src[12] = portb_lo_group_trig_i;
  assign trig_src[11] = spi_irq_i;
  assign trig_src[10] = porta_top_group_trig_i;
  assign trig_src[9] = serial_port_two_irq_i;
  assign trig_src[8] = serial_port_one_irq_i;
  assign trig_src[7] = basic_timer_three_irq_i;
  assign trig_src[6] = basic_timer_two_irq_i;
  assign trig_src[5] = basic_timer_one_irq_i;
  assign trig_src[4] = porta_upper_group_trig_i;
  assign trig_src[3] = porta_mid_group_trig_i;
  assign trig_src[2] = porta_lo_group_trig_i;
  assign trig_src[1] = general_timer_irq_i;
  assign trig_src[0] = advanced_timer_trig_i;

  adctw_trig #(
    .NSRC(`ADCTW_NTRIG)
  ) u_trig (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .src_i(trig_src),
    .en_i(conversion_trigger_select_q),
    .hit_o(trig_hit)
  );

  assign sw_start = reg_wr_i && (reg_addr_i == `ADCTW_OFS_START) &&
                    reg_wdata_i[`ADCTW_START_BIT];
  // Starts are dropped, not queued, while a conversion runs.
  assign launch = (sw_start | trig_hit) & (state_q == adctw_pkg::st_idle);
  assign conv_start_o = launch;

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= adctw_pkg::st_idle;
    end else begin
      case (state_q)
        adctw_pkg::st_idle: begin
          if (launch) begin
            state_q <= adctw_pkg::st_busy;
          end
        end
        adctw_pkg::st_busy: begin
          if (conv_done_i) begin
            state_q <= adctw_pkg::st_idle;
          end
        end
        default: begin
          state_q <= adctw_pkg::st_idle;
        end
      endcase
    end
  end

  // The channel is latched at launch so that a rewrite during a conversion
  // cannot mislabel the result seen by the watchdog.
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      conv_chan_q <= `ADCTW_RST_CHAN;
    end else if (launch) begin
      conv_chan_q <= channel_select;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl0_q <= `ADCTW_RST_CR0;
    end else if (reg_wr_i && (reg_addr_i == `ADCTW_OFS_CR0)) begin
      ctrl0_q <= reg_wdata_i[15:0];
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl1_q <= `ADCTW_RST_CR1;
    end else if (reg_wr_i && (reg_addr_i == `ADCTW_OFS_CR1)) begin
      ctrl1_q <= reg_wdata_i[8:0];
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      conversion_trigger_select_q <= `ADCTW_RST_TRIG;
    end else if (reg_wr_i && (reg_addr_i == `ADCTW_OFS_TRIG)) begin
      conversion_trigger_select_q <= reg_wdata_i[`ADCTW_NTRIG-1:0];
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      high_threshold_q <= `ADCTW_RST_VTH;
      low_threshold_q <= `ADCTW_RST_VTL;
    end else if (reg_wr_i && (reg_addr_i == `ADCTW_OFS_VTH)) begin
      high_threshold_q <= reg_wdata_i[`ADCTW_RW-1:0];
    end else if (reg_wr_i && (reg_addr_i == `ADCTW_OFS_VTL)) begin
      low_threshold_q <= reg_wdata_i[`ADCTW_RW-1:0];
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_enable_reg_q <= `ADCTW_RST_FLAG;
    end else if (reg_wr_i && (reg_addr_i == `ADCTW_OFS_IER)) begin
      irq_enable_reg_q <= reg_wdata_i[`ADCTW_NFLAG-1:0];
    end
  end

  // Every mode lands its latest result here; mode 0 reads it directly.
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      result_slot_zero_q <= `ADCTW_RST_RES;
    end else if (conv_done_i) begin
      result_slot_zero_q <= conv_result_i;
    end
  end

  assign wd_bus.valid = conv_done_i;
  assign wd_bus.result = conv_result_i;
  assign wd_bus.vth = high_threshold_q;
  assign wd_bus.vtl = low_threshold_q;
  assign wd_bus.armed = watchdog_global_enable &&
                        (conv_chan_q == watchdog_channel_select);

  adctw_wdog u_wdog (
    .cmp(wd_bus.cmp)
  );

  always_comb begin
    flag_set = '0;
    flag_set[`ADCTW_F_EOC] = conv_done_i;
    // A new result while the previous completion is still flagged is lost data.
    flag_set[`ADCTW_F_OVW] = conv_done_i & irq_flag_reg_q[`ADCTW_F_EOC];
    flag_set[`ADCTW_F_EOS] = sequence_done_i;
    flag_set[`ADCTW_F_EOA] = all_conversions_done_i;
    flag_set[`ADCTW_F_HIGH] = wd_bus.hit_high;
    flag_set[`ADCTW_F_LOW] = wd_bus.hit_low;
    flag_set[`ADCTW_F_INR] = wd_bus.hit_inr;
  end

  always_comb begin
    flag_keep = '1;
    if (reg_wr_i && (reg_addr_i == `ADCTW_OFS_ICR)) begin
      flag_keep = reg_wdata_i[`ADCTW_NFLAG-1:0];
    end
  end

  // A set arriving with its clear wins, so no event is lost.
  assign irq_flag_reg_d = (irq_flag_reg_q & flag_keep) | flag_set;

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_flag_reg_q <= `ADCTW_RST_FLAG;
    end else begin
      irq_flag_reg_q <= irq_flag_reg_d;
    end
  end

  assign irq_o = |(irq_flag_reg_q & irq_enable_reg_q);

  always_comb begin
    rdata_d = '0;
    if (reg_addr_i == `ADCTW_OFS_CR0) begin
      rdata_d[15:0] = ctrl0_q;
    end else if (reg_addr_i == `ADCTW_OFS_CR1) begin
      rdata_d[8:0] = ctrl1_q;
    end else if (reg_addr_i == `ADCTW_OFS_START) begin
      rdata_d[`ADCTW_START_BIT] = (state_q == adctw_pkg::st_busy);
    end else if (reg_addr_i == `ADCTW_OFS_VTH) begin
      rdata_d[`ADCTW_RW-1:0] = high_threshold_q;
    end else if (reg_addr_i == `ADCTW_OFS_VTL) begin
      rdata_d[`ADCTW_RW-1:0] = low_threshold_q;
    end else if (reg_addr_i == `ADCTW_OFS_TRIG) begin
      rdata_d[`ADCTW_NTRIG-1:0] = conversion_trigger_select_q;
    end else if (reg_addr_i == `ADCTW_OFS_RES0) begin
      rdata_d[`ADCTW_RW-1:0] = result_slot_zero_q;
    end else if (reg_addr_i == `ADCTW_OFS_IER) begin
      rdata_d[`ADCTW_NFLAG-1:0] = irq_enable_reg_q;
    end else if (reg_addr_i == `ADCTW_OFS_ISR) begin
      rdata_d[`ADCTW_NFLAG-1:0] = irq_flag_reg_q;
    end
  end

  // The data stand for one cycle only; idle cycles return zero.
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_q <= '0;
    end else if (reg_rd_i) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= '0;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign conv_channel_o = conv_chan_q;
  assign conv_mode_o = ctrl0_q[`ADCTW_CR0_MODE_HI:`ADCTW_CR0_MODE_LO];
  assign temp_sensor_enable_o = ctrl0_q[`ADCTW_CR0_TEMP_SENSOR_ENABLE];
  assign temp_route_o = (conv_chan_q == `ADCTW_CH_TEMP);
  // The follower is only software's to switch; the sensor path needs it on.
  assign follower_enable_o = ctrl0_q[`ADCTW_CR0_BUF];
endmodule : adctw_top

/* logic/adctw_trig.sv */
`timescale 1ns/10ps
module adctw_trig #(
  parameter int NSRC = 16
) (
  input wire logic sys_clk_i, // Block clock.
  input wire logic sys_rst_i, // Asynchronous reset.
  input wire logic [NSRC-1:0] src_i, // Raw trigger levels.
  input wire logic [NSRC-1:0] en_i, // Per-source enables.
  output logic hit_o // Enabled rising edge seen.
);
  logic [NSRC-1:0] prev_q;
  logic [NSRC-1:0] rise;
  generate
    if (NSRC < 1) begin : g_bad
      $error("adctw_trig needs at least one source");
    end
    for (genvar i = 0; i < NSRC; i++) begin : g_src
      // A held-high interrupt line must launch only one conversion.
      always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          prev_q[i] <= 1'b0;
        end else begin
          prev_q[i] <= src_i[i];
        end
      end
      assign rise[i] = src_i[i] & ~prev_q[i] & en_i[i];
    end
  endgenerate
  assign hit_o = |rise;
endmodule : adctw_trig

/* logic/adctw_wdog.sv */
`timescale 1ns/10ps
module adctw_wdog (
  adctw_cmp_if.cmp cmp // Comparison request and verdict.
);
  logic go;
  assign go = cmp.valid & cmp.armed;
  assign cmp.hit_high = go & (cmp.result >= cmp.vth);
  assign cmp.hit_low = go & (cmp.result < cmp.vtl);
  assign cmp.hit_inr = go & (cmp.result >= cmp.vtl) & (cmp.result < cmp.vth);
endmodule : adctw_wdog

/* tb/adctw_src_model.sv */
`timescale 1ns/10ps
module adctw_src_model (
  input wire logic sys_clk_i, // Clock.
  input wire logic sys_rst_i, // Reset.
  input wire logic conv_start_i, // Launch from the block.
  input wire logic [3:0] lat_i, // Cycles from launch to result.
  input wire logic [11:0] res_i, // Result to return.
  output logic [15:0] trig_o, // Trigger source levels.
  output logic conv_done_o, // Result valid pulse.
  output logic [11:0] conv_result_o, // Result, scrambled when not valid.
  output logic seq_done_o, // Sequence finished pulse.
  output logic all_done_o // Multiple conversions finished pulse.
);
  logic [3:0] cnt_q;
  int starts;
  // Outside the valid pulse the result bus carries the inverse, so a late sample shows.
  assign conv_result_o = conv_done_o ? res_i : ~res_i;
  initial begin
    trig_o = 16'h0000;
    seq_done_o = 1'b0;
    all_done_o = 1'b0;
  end
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_q <= 4'h0;
      conv_done_o <= 1'b0;
      starts <= 0;
    end else begin
      conv_done_o <= cnt_q == 4'h1;
      if (conv_start_i) begin
        cnt_q <= lat_i;
        starts <= starts + 1;
      end else if (cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
  task automatic fire(input int i);
    @(posedge sys_clk_i);
    trig_o[i] <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    trig_o[i] <= 1'b0;
  endtask : fire
  task automatic pulse(input bit all);
    @(posedge sys_clk_i);
    if (all) begin
      all_done_o <= 1'b1;
    end else begin
      seq_done_o <= 1'b1;
    end
    @(posedge sys_clk_i);
    all_done_o <= 1'b0;
    seq_done_o <= 1'b0;
  endtask : pulse
endmodule : adctw_src_model

/* tb/adctw_top_properties.sv */
`timescale 1ns/10ps
module adctw_top_properties (
  input wire logic sys_clk_i, // Clock.
  input wire logic sys_rst_i, // Reset.
  input wire logic [5:0] reg_addr_i, // Watched.
  input wire logic [31:0] reg_wdata_i, // Watched.
  input wire logic reg_wr_i, // Watched.
  input wire logic reg_rd_i, // Watched.
  input wire logic [31:0] reg_rdata_o, // Watched.
  input wire logic portb_hi_group_trig_i, // Watched.
  input wire logic portb_mid_group_trig_i, // Watched.
  input wire logic portb_lo_group_trig_i, // Watched.
  input wire logic porta_top_group_trig_i, // Watched.
  input wire logic porta_upper_group_trig_i, // Watched.
  input wire logic porta_mid_group_trig_i, // Watched.
  input wire logic porta_lo_group_trig_i, // Watched.
  input wire logic i2c_irq_i, // Watched.
  input wire logic spi_irq_i, // Watched.
  input wire logic serial_port_two_irq_i, // Watched.
  input wire logic serial_port_one_irq_i, // Watched.
  input wire logic basic_timer_three_irq_i, // Watched.
  input wire logic basic_timer_two_irq_i, // Watched.
  input wire logic basic_timer_one_irq_i, // Watched.
  input wire logic general_timer_irq_i, // Watched.
  input wire logic advanced_timer_trig_i, // Watched.
  input wire logic conv_start_o, // Watched.
  input wire logic [3:0] conv_channel_o, // Watched.
  input wire logic [2:0] conv_mode_o, // Watched.
  input wire logic temp_sensor_enable_o, // Watched.
  input wire logic temp_route_o, // Watched.
  input wire logic follower_enable_o, // Watched.
  input wire logic conv_done_i, // Watched.
  input wire logic sequence_done_i, // Watched.
  input wire logic all_conversions_done_i, // Watched.
  input wire logic irq_o // Watched.
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  logic [15:0] src, prev_q, trig_q, cr0_q, hit;
  logic [8:0] cr1_q;
  logic [6:0] ier_q;
  logic busy_q, sw_start;
  assign src = {portb_hi_group_trig_i, portb_mid_group_trig_i, i2c_irq_i, portb_lo_group_trig_i,
    spi_irq_i, porta_top_group_trig_i, serial_port_two_irq_i, serial_port_one_irq_i,
    basic_timer_three_irq_i, basic_timer_two_irq_i, basic_timer_one_irq_i,
    porta_upper_group_trig_i, porta_mid_group_trig_i, porta_lo_group_trig_i,
    general_timer_irq_i, advanced_timer_trig_i};
  assign hit = src & ~prev_q & trig_q;
  assign sw_start = reg_wr_i && reg_addr_i == 6'h08 && reg_wdata_i[0];
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      {prev_q, trig_q, cr0_q, cr1_q, ier_q, busy_q} <= '0;
    end else begin
      prev_q <= src;
      busy_q <= conv_start_o | (busy_q & ~conv_done_i);
      if (reg_wr_i && reg_addr_i == 6'h1C) trig_q <= reg_wdata_i[15:0];
      if (reg_wr_i && reg_addr_i == 6'h00) cr0_q <= reg_wdata_i[15:0];
      if (reg_wr_i && reg_addr_i == 6'h04) cr1_q <= reg_wdata_i[8:0];
      if (reg_wr_i && reg_addr_i == 6'h34) ier_q <= reg_wdata_i[6:0];
    end
  end
  property p_rd_idle; !$past(reg_rd_i) |-> reg_rdata_o == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_start_idle; conv_start_o |-> !busy_q; endproperty
  a_start_idle: assert property (p_start_idle) else $error("start while busy");
  property p_trig_start; !busy_q && hit != 16'h0 |-> conv_start_o; endproperty
  a_trig_start: assert property (p_trig_start) else $error("trigger lost");
  property p_soft_start; !busy_q && sw_start |-> conv_start_o; endproperty
  a_soft_start: assert property (p_soft_start) else $error("software start lost");
  property p_start_cause; conv_start_o |-> sw_start || hit != 16'h0; endproperty
  a_start_cause: assert property (p_start_cause) else $error("start without cause");
  property p_irq_en; irq_o |-> ier_q != 7'h00; endproperty
  a_irq_en: assert property (p_irq_en) else $error("request while masked");
  property p_chan;
    conv_start_o |=> conv_channel_o == $past(cr1_q[3:0])
      && temp_route_o == ($past(cr1_q[3:0]) == 4'hE);
  endproperty
  a_chan: assert property (p_chan) else $error("channel not latched");
  property p_cr0;
    temp_sensor_enable_o == cr0_q[5] && conv_mode_o == cr0_q[4:2]
      && follower_enable_o == cr0_q[13];
  endproperty
  a_cr0: assert property (p_cr0) else $error("control outputs differ");
  property p_eoc_irq; conv_done_i && ier_q[0] && !reg_wr_i |=> irq_o; endproperty
  a_eoc_irq: assert property (p_eoc_irq) else $error("done without request");
  property p_ev_irq;
    (sequence_done_i && ier_q[1] || all_conversions_done_i && ier_q[2]) && !reg_wr_i |=> irq_o;
  endproperty
  a_ev_irq: assert property (p_ev_irq) else $error("event without request");
endmodule : adctw_top_properties
bind adctw_top adctw_top_properties i_adctw_top_properties (.*);

/* tb/testbench.sv */
`timescale 1ns/10ps
module testbench;
  logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [5:0] reg_addr_i = 6'h00;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
  logic portb_hi_group_trig_i, portb_mid_group_trig_i, portb_lo_group_trig_i, spi_irq_i;
  logic porta_top_group_trig_i, porta_upper_group_trig_i, porta_mid_group_trig_i, i2c_irq_i;
  logic porta_lo_group_trig_i, serial_port_two_irq_i, serial_port_one_irq_i;
  logic basic_timer_three_irq_i, basic_timer_two_irq_i, basic_timer_one_irq_i;
  logic general_timer_irq_i, advanced_timer_trig_i, conv_start_o, temp_sensor_enable_o;
  logic temp_route_o, follower_enable_o, irq_o, conv_done_i, sequence_done_i;
  logic all_conversions_done_i;
  logic [3:0] conv_channel_o, lat = 4'h3;
  logic [2:0] conv_mode_o;
  logic [11:0] conv_result_i, res = 12'h000;
  logic [15:0] trg;
  int errors = 0, check_count = 0;
  always #2.5 sys_clk_i = ~sys_clk_i;
  assign {portb_hi_group_trig_i, portb_mid_group_trig_i, i2c_irq_i, portb_lo_group_trig_i,
    spi_irq_i, porta_top_group_trig_i, serial_port_two_irq_i, serial_port_one_irq_i,
    basic_timer_three_irq_i, basic_timer_two_irq_i, basic_timer_one_irq_i,
    porta_upper_group_trig_i, porta_mid_group_trig_i, porta_lo_group_trig_i,
    general_timer_irq_i, advanced_timer_trig_i} = trg;
  adctw_top i_adctw_top (.*);
  adctw_src_model i_adctw_src_model (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .conv_start_i(conv_start_o), .lat_i(lat), .res_i(res), .trig_o(trg),
    .conv_done_o(conv_done_i), .conv_result_o(conv_result_i), .seq_done_o(sequence_done_i),
    .all_done_o(all_conversions_done_i));
  task automatic close_out;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    @(posedge sys_clk_i);
    d = reg_rdata_o;
  endtask : rd
  task automatic rchk(input string name, input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(name, d, exp);
  endtask : rchk
  // Polls the busy bit so the bench never assumes a fixed conversion time.
  task automatic conv(input logic [11:0] r, input bit go);
    logic [31:0] d;
    res <= r;
    if (go) wr(6'h08, 32'h1);
    for (int n = 0; n < 30; n++) begin
      rd(6'h08, d);
      if (d[0] === 1'b0) return;
    end
    errors++;
    close_out();
  endtask : conv
  task automatic t_reset;
    logic [5:0] a [9] = '{6'h00, 6'h04, 6'h08, 6'h14, 6'h18, 6'h1C, 6'h20, 6'h34, 6'h3C};
    for (int i = 0; i < 9; i++) rchk("reset value", a[i], a[i] == 6'h14 ? 32'hFFF : 32'h0);
    chk("sensor off", temp_sensor_enable_o, 32'h0);
    wr(6'h1C, 32'hFFFFA5C3);
    rchk("trigger select", 6'h1C, 32'h0000A5C3);
    rchk("unmapped", 6'h0C, 32'h0);
    wr(6'h00, 32'h001C);
    rchk("control zero", 6'h00, 32'h001C);
    chk("mode field", conv_mode_o, 32'h7);
  endtask : t_reset
  task automatic t_trig;
    int s;
    for (int i = 0; i < 16; i++) begin
      wr(6'h1C, 32'h1 << i);
      s = i_adctw_src_model.starts;
      i_adctw_src_model.fire((i + 1) % 16);
      i_adctw_src_model.fire(i);
      conv(12'h055, 1'b0);
      chk("trigger starts", i_adctw_src_model.starts - s, 32'h1);
    end
  endtask : t_trig
  task automatic t_busy;
    int s;
    lat <= 4'hF;
    wr(6'h1C, 32'h1);
    s = i_adctw_src_model.starts;
    wr(6'h08, 32'h1);
    i_adctw_src_model.fire(0);
    wr(6'h08, 32'h1);
    conv(12'h055, 1'b0);
    chk("starts while busy", i_adctw_src_model.starts - s, 32'h1);
    lat <= 4'h3;
  endtask : t_busy
  task automatic t_wdog;
    logic [11:0] r [8] = '{12'h0FF, 12'h100, 12'h7FF, 12'h800, 12'hFFF, 12'h000, 12'h800, 12'h800};
    logic [8:0] c [8] = '{9'h133, 9'h133, 9'h133, 9'h133, 9'h133, 9'h133, 9'h033, 9'h143};
    logic [6:0] f [8] = '{7'h09, 7'h21, 7'h21, 7'h11, 7'h11, 7'h09, 7'h01, 7'h01};
    wr(6'h14, 32'h800);
    wr(6'h18, 32'h100);
    for (int i = 0; i < 8; i++) begin
      wr(6'h04, {23'h0, c[i]});
      wr(6'h38, 32'h0);
      conv(r[i], 1'b1);
      rchk("watchdog flags", 6'h3C, {25'h0, f[i]});
      rchk("result", 6'h20, {20'h0, r[i]});
    end
  endtask : t_wdog
  task automatic t_irq;
    wr(6'h04, 32'h0);
    wr(6'h38, 32'h0);
    wr(6'h34, 32'h7F);
    conv(12'h123, 1'b1);
    chk("done request", irq_o, 32'h1);
    wr(6'h38, 32'hFFFFFFFE);
    rchk("cleared", 6'h3C, 32'h0);
    conv(12'h124, 1'b1);
    conv(12'h125, 1'b1);
    rchk("overflow", 6'h3C, 32'h41);
    i_adctw_src_model.pulse(1'b0);
    i_adctw_src_model.pulse(1'b1);
    rchk("sequence flags", 6'h3C, 32'h47);
    wr(6'h38, 32'hFFFFFFBF);
    rchk("one cleared", 6'h3C, 32'h07);
    wr(6'h34, 32'h0);
    @(negedge sys_clk_i);
    chk("masked", irq_o, 32'h0);
    wr(6'h34, 32'h4);
    @(negedge sys_clk_i);
    chk("all done request", irq_o, 32'h1);
    wr(6'h38, 32'h0);
    @(negedge sys_clk_i);
    chk("request gone", irq_o, 32'h0);
  endtask : t_irq
  task automatic t_temp;
    wr(6'h00, 32'h2020);
    wr(6'h04, 32'h00E);
    wr(6'h38, 32'h0);
    conv(12'h8CB, 1'b1);
    chk("sensor on", temp_sensor_enable_o, 32'h1);
    chk("follower", follower_enable_o, 32'h1);
    chk("sensor routed", temp_route_o, 32'h1);
    chk("channel", conv_channel_o, 32'hE);
    chk("single mode", conv_mode_o, 32'h0);
    rchk("sensor result", 6'h20, 32'h8CB);
    rchk("done flag", 6'h3C, 32'h01);
  endtask : t_temp
  initial begin
    repeat (16) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_trig();
    t_busy();
    t_wdog();
    t_irq();
    t_temp();
    close_out();
  end
  initial begin
    #100000;
    errors++;
    close_out();
  end
endmodule : testbench
